// [core/dual_stepper_core.sv]
`timescale 1ns/1ps
`include "stepper_params.svh"

module dual_stepper_core #(
	parameter int ADDR_W = 8
) (
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// per-motor control pins, index 0 = AB, 1 = CD
	input wire logic [1:0] step_pulse_in,
	input wire logic [1:0] direction_in,
	input wire logic [1:0] decay_select_in,
	input wire logic [1:0] microstep_mode_hi,
	input wire logic [1:0] microstep_mode_lo,
	input wire logic [1:0] indexer_reset_n,
	input wire logic pair1_enable_n,
	input wire logic pair2_enable_n,
	// sense and reference codes, bridges A B C D and motors AB CD
	input wire logic [3:0][7:0] current_sense_node,
	input wire logic [1:0][7:0] reference_voltage_in,
	// bridge outputs, enables low while driven
	output logic [3:0] bridge_out_pos,
	output logic [3:0] bridge_out_pos_oe_n,
	output logic [3:0] bridge_out_neg,
	output logic [3:0] bridge_out_neg_oe_n,
	// axi4-lite write address and data
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	localparam int SYNC_W = 62;
	localparam logic [9:0] BLANK_CNT = 10'(`BLANK_CYCLES);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [SYNC_W-1:0] sync1_reg, sync2_reg, sync_in;
	logic [1:0] step_s, dir_s, decay_s, mhi_s, mlo_s, rst_n_s, en_n_s;
	logic [3:0][7:0] sense_s;
	logic [1:0][7:0] vref_s;
	logic [1:0] step_prev_reg;

	assign sync_in = {step_pulse_in, direction_in, decay_select_in,
		microstep_mode_hi, microstep_mode_lo, indexer_reset_n,
		pair2_enable_n, pair1_enable_n, current_sense_node,
		reference_voltage_in};
	assign {step_s, dir_s, decay_s, mhi_s, mlo_s, rst_n_s, en_n_s,
		sense_s, vref_s} = sync2_reg;

	// two stages, then step edge history
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			step_prev_reg <= 2'h0;
		end else if (ce) begin
			sync1_reg <= sync_in;
			sync2_reg <= sync1_reg;
			step_prev_reg <= step_s;
		end
	end

	// ------------------------------------------------------------
	// sleep, reset and per-motor activity
	// ------------------------------------------------------------
	logic sleep;
	logic [1:0] home, act, step_rise;

	assign sleep = en_n_s[0] & en_n_s[1];
	// reset holds home and blocks steps
	assign home = ~rst_n_s | {2{sleep}};
	assign step_rise = step_s & ~step_prev_reg & ~home;
	assign act = ~en_n_s & rst_n_s & {2{~sleep}};

	// ------------------------------------------------------------
	// indexers
	// ------------------------------------------------------------
	logic [4:0] pos_m [2];
	stepper_pkg::level_t lvl_a [2];
	stepper_pkg::level_t lvl_b [2];
	logic dec_a [2];
	logic dec_b [2];

	for (genvar m = 0; m < 2; m++) begin : g_motor
		microstep_indexer u_indexer (
			.aclk(aclk),
			.aresetn(aresetn),
			.ce(ce),
			.home(home[m]),
			.step_rise(step_rise[m]),
			.dir(dir_s[m]),
			.mode({mhi_s[m], mlo_s[m]}),
			.pos(pos_m[m]),
			.level_a(lvl_a[m]),
			.level_b(lvl_b[m]),
			.dec_a(dec_a[m]),
			.dec_b(dec_b[m])
		);
	end

	// ------------------------------------------------------------
	// pwm timebase
	// ------------------------------------------------------------
	logic [15:0] period_reg, period_next;
	logic [15:0] pwm_cnt_reg, pwm_cnt_next;
	logic [15:0] mixed_cnt;
	logic cycle_start, past_mixed;

	assign mixed_cnt = 16'((32'(period_reg) * `MIXED_DECAY_PCT) / 100);
	assign cycle_start = (pwm_cnt_reg == 16'h0000) & ~sleep;
	assign past_mixed = pwm_cnt_reg >= mixed_cnt;

	// free-running period counter, stopped in sleep
	always_comb begin
		pwm_cnt_next = pwm_cnt_reg;
		if (sleep)
			pwm_cnt_next = 16'h0000;
		else if (pwm_cnt_reg >= period_reg - 16'h0001)
			pwm_cnt_next = 16'h0000;
		else
			pwm_cnt_next = pwm_cnt_reg + 16'h0001;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			pwm_cnt_reg <= 16'h0000;
		else if (ce)
			pwm_cnt_reg <= pwm_cnt_next;
	end

	// ------------------------------------------------------------
	// bridge choppers
	// ------------------------------------------------------------
	logic [3:0] pos_next, pos_oe_next, neg_next, neg_oe_next;
	logic [3:0] drive_now;

	// scaled comparison: 5 * sense * 100 >= vref * level
	function automatic logic chop_trip(input logic [7:0] sense,
			input logic [7:0] vref, input logic [6:0] mag);
		logic [17:0] lhs;
		logic [17:0] rhs;
		lhs = 18'(sense) * 18'(`SENSE_GAIN * `FULL_SCALE_PCT);
		rhs = 18'(vref) * 18'(mag);
		chop_trip = lhs >= rhs;
	endfunction

	for (genvar b = 0; b < 4; b++) begin : g_bridge
		localparam int M = b / 2;
		stepper_pkg::chop_phase_t ph_reg, ph_next;
		logic [9:0] blank_reg, blank_next;
		stepper_pkg::level_t lvl;
		logic [6:0] mag;
		logic dec, neg, trip, mixed_ok;

		assign lvl = (b % 2 == 0) ? lvl_a[M] : lvl_b[M];
		assign dec = (b % 2 == 0) ? dec_a[M] : dec_b[M];
		assign neg = lvl[7];
		assign mag = neg ? 7'(-lvl) : lvl[6:0];
		assign trip = chop_trip(sense_s[b], vref_s[M], mag);
		assign mixed_ok = decay_s[M] & dec;

		always_comb begin
			ph_next = ph_reg;
			blank_next = blank_reg;
			if (!act[M]) begin
				ph_next = stepper_pkg::PH_IDLE;
			end else if (cycle_start) begin
				ph_next = stepper_pkg::PH_DRIVE;
				blank_next = 10'h000;
			end else begin
				case (ph_reg)
					stepper_pkg::PH_DRIVE: begin
						if (blank_reg < BLANK_CNT)
							blank_next = blank_reg + 10'h001;
						else if (trip)
							ph_next = mixed_ok ? stepper_pkg::PH_FAST
								: stepper_pkg::PH_SLOW;
					end
					stepper_pkg::PH_FAST: begin
						if (past_mixed)
							ph_next = stepper_pkg::PH_SLOW;
						else if (sense_s[b] <= `ZERO_SENSE_CODE)
							ph_next = stepper_pkg::PH_FLOAT;
					end
					stepper_pkg::PH_FLOAT: begin
						if (past_mixed)
							ph_next = stepper_pkg::PH_SLOW;
					end
					stepper_pkg::PH_SLOW: ph_next = ph_reg;
					stepper_pkg::PH_IDLE: ph_next = ph_reg;
					default: ph_next = stepper_pkg::PH_IDLE;
				endcase
			end
		end

		// output levels for the coming phase
		always_comb begin
			pos_next[b] = 1'b0;
			neg_next[b] = 1'b0;
			pos_oe_next[b] = 1'b1;
			neg_oe_next[b] = 1'b1;
			case (ph_next)
				stepper_pkg::PH_DRIVE: begin
					pos_next[b] = ~neg;
					neg_next[b] = neg;
					pos_oe_next[b] = 1'b0;
					neg_oe_next[b] = 1'b0;
				end
				stepper_pkg::PH_FAST: begin
					pos_next[b] = neg;
					neg_next[b] = ~neg;
					pos_oe_next[b] = 1'b0;
					neg_oe_next[b] = 1'b0;
				end
				stepper_pkg::PH_SLOW: begin
					pos_oe_next[b] = 1'b0;
					neg_oe_next[b] = 1'b0;
				end
				default: pos_next[b] = 1'b0;
			endcase
		end

		assign drive_now[b] = ph_reg == stepper_pkg::PH_DRIVE;

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ph_reg <= stepper_pkg::PH_IDLE;
				blank_reg <= 10'h000;
			end else if (ce) begin
				ph_reg <= ph_next;
				blank_reg <= blank_next;
			end
		end
	end

	// registered bridge pins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bridge_out_pos <= 4'h0;
			bridge_out_neg <= 4'h0;
			bridge_out_pos_oe_n <= 4'hf;
			bridge_out_neg_oe_n <= 4'hf;
		end else if (ce) begin
			bridge_out_pos <= pos_next;
			bridge_out_neg <= neg_next;
			bridge_out_pos_oe_n <= pos_oe_next;
			bridge_out_neg_oe_n <= neg_oe_next;
		end
	end

	// ------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------
	logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
	logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next, rdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic bvalid_next, rvalid_next;
	logic [1:0] bresp_next, rresp_next;
	logic [15:0] wr_val;
	logic do_write, rd_take;

	assign do_write = aw_full_reg & w_full_reg & ~s_axi_bvalid;
	assign rd_take = s_axi_arvalid & s_axi_arready;
	assign wr_val = {wstrb_reg[1] ? wdata_reg[15:8] : period_reg[15:8],
		wstrb_reg[0] ? wdata_reg[7:0] : period_reg[7:0]};

	// write channels, response and period register
	always_comb begin
		aw_full_next = aw_full_reg;
		w_full_next = w_full_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = s_axi_bvalid;
		bresp_next = s_axi_bresp;
		period_next = period_reg;
		if (s_axi_awvalid & s_axi_awready) begin
			aw_full_next = 1'b1;
			awaddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid & s_axi_wready) begin
			w_full_next = 1'b1;
			wdata_next = s_axi_wdata;
			wstrb_next = s_axi_wstrb;
		end
		if (s_axi_bvalid & s_axi_bready)
			bvalid_next = 1'b0;
		if (do_write) begin
			aw_full_next = 1'b0;
			w_full_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = `RESP_SLVERR;
			if (awaddr_reg == `REG_PERIOD) begin
				bresp_next = `RESP_OKAY;
				period_next = (wr_val < 16'(`MIN_PERIOD_CYCLES))
					? 16'(`MIN_PERIOD_CYCLES) : wr_val;
			end
		end
	end

	// read channel with register decode
	always_comb begin
		rvalid_next = s_axi_rvalid;
		rdata_next = s_axi_rdata;
		rresp_next = s_axi_rresp;
		if (s_axi_rvalid & s_axi_rready)
			rvalid_next = 1'b0;
		if (rd_take) begin
			rvalid_next = 1'b1;
			rresp_next = `RESP_OKAY;
			rdata_next = 32'h0000_0000;
			case (s_axi_araddr)
				`REG_STATUS: begin
					rdata_next[`STAT_POS_AB_LSB +: 5] = pos_m[0];
					rdata_next[`STAT_POS_CD_LSB +: 5] = pos_m[1];
					rdata_next[`STAT_SLEEP_BIT] = sleep;
					rdata_next[`STAT_DRIVE_LSB +: 4] = drive_now;
				end
				`REG_PERIOD: rdata_next[15:0] = period_reg;
				`REG_LEVELS: rdata_next = {lvl_b[1], lvl_a[1],
					lvl_b[0], lvl_a[0]};
				default: rresp_next = `RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			period_reg <= `PERIOD_RESET;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (ce) begin
			aw_full_reg <= aw_full_next;
			w_full_reg <= w_full_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			period_reg <= period_next;
			s_axi_awready <= ~aw_full_next;
			s_axi_wready <= ~w_full_next;
			s_axi_bvalid <= bvalid_next;
			s_axi_bresp <= bresp_next;
			s_axi_arready <= ~rvalid_next;
			s_axi_rvalid <= rvalid_next;
			s_axi_rdata <= rdata_next;
			s_axi_rresp <= rresp_next;
		end
	end

endmodule

// [core/microstep_indexer.sv]
`timescale 1ns/1ps
`include "stepper_params.svh"

module microstep_indexer (
	// clock and control
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// motor inputs, already synchronised
	input wire logic home,
	input wire logic step_rise,
	input wire logic dir,
	input wire logic [1:0] mode,
	// table position and winding levels
	output logic [4:0] pos,
	output stepper_pkg::level_t level_a,
	output stepper_pkg::level_t level_b,
	output logic dec_a,
	output logic dec_b
);

	logic [4:0] pos_reg, pos_next;
	logic dec_a_reg, dec_a_next, dec_b_reg, dec_b_next;
	logic [4:0] incr;
	stepper_pkg::level_t new_a, new_b;

	// magnitude of cos(n * 11.25 deg), n = 0..8
	function automatic logic [6:0] mag_of(input logic [3:0] n);
		case (n)
			4'h0: mag_of = 7'h64;
			4'h1: mag_of = 7'h62;
			4'h2: mag_of = 7'h5c;
			4'h3: mag_of = 7'h53;
			4'h4: mag_of = 7'h47;
			4'h5: mag_of = 7'h38;
			4'h6: mag_of = 7'h26;
			4'h7: mag_of = 7'h14;
			default: mag_of = 7'h00;
		endcase
	endfunction

	// signed cosine level at a 32-entry table index
	function automatic stepper_pkg::level_t cos_of(input logic [4:0] idx);
		logic [3:0] k;
		logic [3:0] k_rev;
		k = {1'b0, idx[2:0]};
		k_rev = 4'h8 - k;
		case (idx[4:3])
			2'h0: cos_of = {1'b0, mag_of(k)};
			2'h1: cos_of = -{1'b0, mag_of(k_rev)};
			2'h2: cos_of = -{1'b0, mag_of(k)};
			default: cos_of = {1'b0, mag_of(k_rev)};
		endcase
	endfunction

	function automatic logic [6:0] abs_of(input stepper_pkg::level_t v);
		abs_of = v[7] ? 7'(-v) : v[6:0];
	endfunction

	assign incr = `FULL_STEP_INCR >> mode;
	assign level_a = cos_of(pos_reg);
	assign level_b = cos_of(pos_reg - `QUARTER_TURN);

	// next position and falling-current flags
	always_comb begin
		pos_next = pos_reg;
		dec_a_next = dec_a_reg;
		dec_b_next = dec_b_reg;
		new_a = level_a;
		new_b = level_b;
		if (home) begin
			pos_next = `HOME_POSITION;
			dec_a_next = 1'b0;
			dec_b_next = 1'b0;
		end else if (step_rise) begin
			pos_next = dir ? pos_reg + incr : pos_reg - incr;
			new_a = cos_of(pos_next);
			new_b = cos_of(pos_next - `QUARTER_TURN);
			dec_a_next = abs_of(new_a) < abs_of(level_a);
			dec_b_next = abs_of(new_b) < abs_of(level_b);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pos_reg <= `HOME_POSITION;
			dec_a_reg <= 1'b0;
			dec_b_reg <= 1'b0;
		end else if (ce) begin
			pos_reg <= pos_next;
			dec_a_reg <= dec_a_next;
			dec_b_reg <= dec_b_next;
		end
	end

	assign pos = pos_reg;
	assign dec_a = dec_a_reg;
	assign dec_b = dec_b_reg;

endmodule

// [pkg/stepper_params.svh]
`ifndef STEPPER_PARAMS_SVH
`define STEPPER_PARAMS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_FREQ_MHZ 125
`define BLANK_TIME_NS 3750
// least time: round up to whole cycles
`define BLANK_CYCLES ((`BLANK_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define PWM_FREQ_KHZ 50
`define PWM_PERIOD_CYCLES (`CLK_FREQ_MHZ * 1000 / `PWM_FREQ_KHZ)
`define MIXED_DECAY_PCT 75
`define MIN_PERIOD_CYCLES (`BLANK_CYCLES + 8)

// ----------------------------------------------------------------
// current regulation and indexer
// ----------------------------------------------------------------
`define SENSE_GAIN 5
`define FULL_SCALE_PCT 100
`define ZERO_SENSE_CODE 8'h02
`define HOME_POSITION 5'h04
`define FULL_STEP_INCR 5'h08
`define QUARTER_TURN 5'h08

// ----------------------------------------------------------------
// register offsets, fields, reset values
// ----------------------------------------------------------------
`define REG_STATUS 8'h00
`define REG_PERIOD 8'h04
`define REG_LEVELS 8'h08
`define STAT_POS_AB_LSB 0
`define STAT_POS_CD_LSB 8
`define STAT_SLEEP_BIT 16
`define STAT_DRIVE_LSB 20
`define PERIOD_RESET 16'h09c4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [pkg/stepper_pkg.sv]
package stepper_pkg;

	// phase of one bridge chopper
	typedef enum logic [2:0] {
		PH_IDLE,
		PH_DRIVE,
		PH_FAST,
		PH_FLOAT,
		PH_SLOW
	} chop_phase_t;

	// signed winding current in percent of full scale
	typedef logic signed [7:0] level_t;

endpackage

// [tb/dual_stepper_core_assertions.sv]
`timescale 1ns/1ps
`include "stepper_params.svh"

// ------------------------------------------------
// port checker for the dual stepper core
// ------------------------------------------------
module dual_stepper_checker #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// motor pins
	input wire logic [1:0] indexer_reset_n,
	input wire logic pair1_enable_n,
	input wire logic pair2_enable_n,
	// bridge outputs
	input wire logic [3:0] bridge_out_pos,
	input wire logic [3:0] bridge_out_pos_oe_n,
	input wire logic [3:0] bridge_out_neg,
	input wire logic [3:0] bridge_out_neg_oe_n,
	// bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp
);
	localparam int BLANK = `BLANK_CYCLES;
	logic [9:0] on_reg;
	logic [9:0] on_next;
	logic drv0;
	logic slow0;
	logic [3:0] off;

	// bridge a states and floated bridges
	assign drv0 = !bridge_out_pos_oe_n[0] && !bridge_out_neg_oe_n[0]
		&& (bridge_out_pos[0] != bridge_out_neg[0]);
	assign slow0 = !bridge_out_pos_oe_n[0] && !bridge_out_neg_oe_n[0]
		&& !bridge_out_pos[0] && !bridge_out_neg[0];
	assign off = bridge_out_pos_oe_n & bridge_out_neg_oe_n;

	// length of the present driven stretch on bridge a
	always_comb begin
		on_next = 10'h000;
		// saturate so a long stretch never wraps back to a short one
		if (aresetn && drv0) begin
			on_next = (on_reg == 10'h3ff) ? on_reg : on_reg + 10'h001;
		end
	end
	always_ff @(posedge aclk) begin
		on_reg <= on_next;
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_DRIVE_MIN: assert property (slow0 && on_reg != 10'h000
		|-> on_reg >= BLANK) else $error("drive shorter than blanking");
	AST_MOTOR_RST: assert property (!indexer_reset_n[0] [*4]
		|=> off[1:0] == 2'b11) else $error("reset motor still driven");
	AST_AB_OFF: assert property (pair1_enable_n [*4]
		|=> off[1:0] == 2'b11) else $error("disabled ab still driven");
	AST_CD_OFF: assert property (pair2_enable_n [*4]
		|=> off[3:2] == 2'b11) else $error("disabled cd still driven");
	AST_SLEEP_OFF: assert property ((pair1_enable_n
		&& pair2_enable_n) [*4] |=> off == 4'hf)
		else $error("sleep left a bridge driven");
	AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready // bus write
		&& s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response late");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready // bus write
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_AW_REFUSE: assert property (s_axi_awvalid && s_axi_awready // bus write
		|=> !s_axi_awready)
		else $error("address taken while one is held");
	AST_W_REFUSE: assert property (s_axi_wvalid && s_axi_wready // bus write
		|=> !s_axi_wready)
		else $error("data taken while one is held");
	AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready // bus read
		|=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready // bus read
		|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data dropped");
endmodule

bind dual_stepper_core dual_stepper_checker #(.ADDR_W(ADDR_W)) u_checker (.*);

// [tb/step_controller_model.sv]
`timescale 1ns/1ps

// ------------------------------------------------
// step and direction controller model
// ------------------------------------------------
module step_controller_model #(
	parameter int HIGH_CYCLES = 313,
	parameter int SETUP_CYCLES = 25,
	parameter int WAKE_CYCLES = 125000
) (
	// clock
	input wire logic aclk,
	// step and direction pins
	output logic [1:0] step_pulse_in,
	output logic [1:0] direction_in
);
	// idle levels at time zero
	initial begin
		step_pulse_in = 2'b00;
		direction_in = 2'b11;
	end

	// one step pulse, direction set up ahead
	task automatic pulse(input int m, input bit d);
		direction_in[m] <= d;
		repeat (SETUP_CYCLES) @(posedge aclk);
		step_pulse_in[m] <= 1'b1;
		repeat (HIGH_CYCLES) @(posedge aclk);
		step_pulse_in[m] <= 1'b0;
		repeat (HIGH_CYCLES) @(posedge aclk);
	endtask

	task automatic wake();
		repeat (WAKE_CYCLES) @(posedge aclk);
	endtask
endmodule

// [tb/test_dual_stepper_core.sv]
`timescale 1ns/1ps
`include "stepper_params.svh"

// ------------------------------------------------
// bench top for the dual stepper core
// ------------------------------------------------
module test_dual_stepper_core;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic ce = 1'b1;
	logic [1:0] step_pulse_in, direction_in, decay_select_in;
	logic [1:0] microstep_mode_hi, microstep_mode_lo, indexer_reset_n;
	logic pair1_enable_n, pair2_enable_n;
	logic [3:0][7:0] current_sense_node;
	logic [1:0][7:0] reference_voltage_in;
	logic [3:0] bridge_out_pos, bridge_out_pos_oe_n;
	logic [3:0] bridge_out_neg, bridge_out_neg_oe_n;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot = 3'h0;
	logic [2:0] s_axi_arprot = 3'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [3:0] st, st_a;
	int n_mismatch = 0;
	int total_checks = 0;
	int pos_m [2];
	int on_len, fast_len, v;

	// clock at 125 mhz
	always #4 aclk = ~aclk;

	// bridge a as {oe pos, oe neg, pos, neg}
	assign st_a = {bridge_out_pos_oe_n[0], bridge_out_neg_oe_n[0],
		bridge_out_pos[0], bridge_out_neg[0]};

	dual_stepper_core u_dual_stepper_core (.*);
	step_controller_model #(.WAKE_CYCLES(1000)) u_step_controller_model (.*);

	// ------------------------------------------------
	// reference model and reporting
	// ------------------------------------------------
	function automatic int cosl(input int i);
		int t [9];
		t = '{100, 98, 92, 83, 71, 56, 38, 20, 0};
		i = i & 31;
		if (i <= 8) return t[i];
		if (i <= 16) return -t[16 - i];
		if (i <= 24) return -t[i - 16];
		return t[32 - i];
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic give_up();
		n_mismatch++;
		test_done();
	endtask

	// ------------------------------------------------
	// bus master tasks
	// ------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		bit ad, wd;
		n = 0;
		ad = 0;
		wd = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ad && wd && s_axi_bvalid)) begin
			@(posedge aclk);
			if (++n > 50) give_up();
			if (!ad && s_axi_awready) begin
				ad = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!wd && s_axi_wready) begin
				wd = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (++n > 50) give_up();
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// positions, sleep flag and winding levels against the model
	task automatic chk_st(input logic slp);
		rd(`REG_STATUS, rdat, resp);
		check(rdat & 32'h0001_1f1f, {15'h0, slp, 3'h0, 5'(pos_m[1]),
			3'h0, 5'(pos_m[0])});
		rd(`REG_LEVELS, rdat, resp);
		check(rdat, {8'(cosl(pos_m[1] - 8)), 8'(cosl(pos_m[1])),
			8'(cosl(pos_m[0] - 8)), 8'(cosl(pos_m[0]))});
	endtask

	// one step through the partner, model follows when it counts
	task automatic step(input int m, input bit d, input bit [1:0] md);
		microstep_mode_hi[m] <= md[1];
		microstep_mode_lo[m] <= md[0];
		u_step_controller_model.pulse(m, d);
		if (indexer_reset_n[m] && !(pair1_enable_n && pair2_enable_n))
			pos_m[m] = (pos_m[m] + (d ? 1 : -1) * (8 >> md)) & 31;
	endtask

	// drive stretch on bridge a, then the state that follows
	task automatic chop();
		int n;
		n = 0;
		on_len = 0;
		fast_len = 0;
		while (st_a === 4'b0010 || n == 0) begin
			@(posedge aclk);
			if (++n > 2000) give_up();
		end
		while (st_a !== 4'b0010) begin
			@(posedge aclk);
			if (++n > 2000) give_up();
		end
		while (st_a === 4'b0010 && on_len < 600) begin
			@(posedge aclk);
			on_len++;
		end
		st = st_a;
		while (st_a === st && fast_len < 600) begin
			@(posedge aclk);
			fast_len++;
		end
	endtask

	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial begin
		decay_select_in = 2'b00;
		microstep_mode_hi = 2'b00;
		microstep_mode_lo = 2'b00;
		indexer_reset_n = 2'b11;
		pair1_enable_n = 1'b0;
		pair2_enable_n = 1'b0;
		current_sense_node = {4{8'hff}};
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		void'($urandom(50));
		reference_voltage_in = {8'($urandom_range(255, 64)),
			8'($urandom_range(255, 64))};
		pos_m = '{4, 4};
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		chk_st(1'b0);
		rd(8'h0c, rdat, resp);
		check(rdat, 32'h0000_0000);
		check(resp, `RESP_SLVERR);
		rd(`REG_PERIOD, rdat, resp);
		check(rdat, 32'(`PERIOD_RESET));
		wr(`REG_STATUS, 32'h0, resp);
		check(resp, `RESP_SLVERR);
		wr(`REG_PERIOD, 32'h64, resp);
		rd(`REG_PERIOD, rdat, resp);
		check(rdat, 32'(`MIN_PERIOD_CYCLES));
		v = $urandom_range(2500, 478);
		wr(`REG_PERIOD, 32'(v), resp);
		rd(`REG_PERIOD, rdat, resp);
		check(rdat, 32'(v));
		$display("register test done");
		for (int md = 0; md < 4; md++) begin
			for (int k = 0; k < 5; k++) begin
				step(0, 1'($urandom), 2'(md));
				chk_st(1'b0);
			end
		end
		for (int k = 0; k < 3; k++) begin
			step(1, 1'($urandom), 2'(k + 1));
			chk_st(1'b0);
		end
		$display("stepping test done");
		indexer_reset_n[0] <= 1'b0;
		step(0, 1'b1, 2'h0);
		pos_m[0] = 4;
		chk_st(1'b0);
		indexer_reset_n[0] <= 1'b1;
		pair1_enable_n <= 1'b1;
		step(0, 1'b1, 2'h3);
		chk_st(1'b0);
		pair2_enable_n <= 1'b1;
		step(1, 1'b1, 2'h0);
		pos_m = '{4, 4};
		chk_st(1'b1);
		pair1_enable_n <= 1'b0;
		pair2_enable_n <= 1'b0;
		u_step_controller_model.wake();
		step(1, 1'b0, 2'h2);
		chk_st(1'b0);
		$display("reset and sleep test done");
		wr(`REG_PERIOD, 32'h320, resp);
		chop();
		check({st, 1'(on_len >= 469 && on_len < 480)}, 5'h01);
		decay_select_in <= 2'b11;
		step(0, 1'b1, 2'h3);
		chop();
		check(st, 4'b0001);
		check(1'(on_len + fast_len >= 597 && on_len + fast_len <= 603), 1);
		check(st_a, 4'b0000);
		// sense collapses during fast decay of the next period
		repeat (700) @(posedge aclk);
		current_sense_node <= '0;
		repeat (8) @(posedge aclk);
		check(st_a, 4'b1100);
		current_sense_node <= {4{8'hff}};
		step(0, 1'b0, 2'h3);
		chop();
		check(st, 4'b0000);
		current_sense_node <= '0;
		// float ab for a moment so the next drive stretch is whole
		pair1_enable_n <= 1'b1;
		repeat (5) @(posedge aclk);
		pair1_enable_n <= 1'b0;
		chop();
		check(on_len, 600);
		$display("chopper test done");
		test_done();
	end
endmodule
